/* core/ucbg_pkg.sv */
// ucbg_pkg: constants for the serial unit clock generator and its data path.
// assumes: one system clock domain, plain register port with one-cycle read data.
package ucbg_pkg;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_CSA = 3'h1;
    localparam logic [2:0] ADDR_CSB = 3'h2;
    localparam logic [2:0] ADDR_CSC = 3'h3;
    localparam logic [2:0] ADDR_DIVL = 3'h4;
    localparam logic [2:0] ADDR_DIVH = 3'h5;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    // status/control a
    localparam int CSA_RXC = 7;
    localparam int CSA_TXC = 6;
    localparam int CSA_DRE = 5;
    localparam int CSA_FE = 4;
    localparam int CSA_DOR = 3;
    localparam int CSA_PE = 2;
    localparam int CSA_U2X = 1;
    // control b
    localparam int CSB_RXEN = 4;
    localparam int CSB_TXEN = 3;
    localparam int CSB_SZ2 = 2;
    localparam int CSB_RXB8 = 1;
    localparam int CSB_TXB8 = 0;
    // control c
    localparam int CSC_DIR = 7;
    localparam int CSC_MSEL = 6;
    localparam int CSC_PM1 = 5;
    localparam int CSC_PM0 = 4;
    localparam int CSC_SBS = 3;
    localparam int CSC_SZ1 = 2;
    localparam int CSC_SZ0 = 1;
    localparam int CSC_POL = 0;
    // ---------------------------------------------------------------
    // reset values and divide factors
    // ---------------------------------------------------------------
    localparam logic [7:0] CSA_RST = 8'h20;
    localparam logic [7:0] CSC_RST = 8'h06;
    localparam logic [3:0] DIV_NORM = 4'hf;
    localparam logic [3:0] DIV_DBL = 4'h7;
    localparam logic [3:0] DIV_SYNC = 4'h1;
    localparam logic [3:0] BITS_FULL = 4'h9;
    localparam logic [3:0] BITS_MIN = 4'h5;
    typedef enum logic [1:0] {UCBG_NORM, UCBG_DBL, UCBG_SMAST, UCBG_SSLV} ucbg_mode_e;
    typedef enum logic [2:0] {UCBG_IDLE, UCBG_START, UCBG_DATA, UCBG_PAR, UCBG_STOP1,
                              UCBG_STOP2} ucbg_fsm_e;
endpackage

/* core/ucbg_top.sv */
// ucbg_top: serial unit with baud generator, transmitter and receiver.
// assumes: inputs synchronous to mclk except the transfer clock pin input.
//
// Overview of operation
// RQ1: four clock modes: normal async, double async, sync master, sync slave.
// RQ2: mode-select bit clear means asynchronous, set means synchronous.
// RQ3: double speed acts only in asynchronous mode.
// RQ4: in sync mode, clock pin direction out means master, in means slave.
// RQ5: transfer clock pin driven or sampled only in synchronous mode.
// RQ6: baud generator clocks async modes and sync master.
// RQ7: down-counter reloads at zero and on divisor low write.
// RQ8: one baud tick per zero; rate is clock over divisor plus one.
// RQ9: transmit bit clock is baud tick divided by 2, 8 or 16.
// RQ10: receiver recovery steps 2, 8 or 16 states per bit.
// RQ11: bit rate clock over 16, 8 or 2 times divisor plus one.
// RQ12: divisor is 12 bits in high and low registers.
// RQ13: one transmit buffer ahead of the shift register, no gap.
// RQ14: two-entry receive buffer read through the data register.
// RQ15: same frame formats; framing, overrun and parity errors flagged.
// RQ16: recovery used for async reception; sync samples on transfer clock.
// RQ17: slave clock passes through synchronisation before use.
// RQ18: software clears the power-reduction bit before use.
// RQ19: three interrupts: transmit complete, data empty, receive complete.
// RQ20: pin sampled by synchroniser then edge detector; two-clock delay.
// RQ21: double speed cuts factor 16 to 8, receiver uses 8 samples.
// RQ22: sync receive samples on edge opposite to transmit change; polarity selects.
// RQ23: slave mode ignores baud counter; external edges time the bits.
`timescale 1ns/1ps
`default_nettype none
module ucbg_top #(
    parameter int DIV_W = 12
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic power_reduce_serial_zero,
    input wire logic rxd_in,
    output logic txd_out,
    input wire logic transfer_clock_pin_in,
    output logic transfer_clock_pin_out,
    output logic transfer_clock_pin_oe,
    output logic irq_rx_complete,
    output logic irq_tx_complete,
    output logic irq_data_empty
);
    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [7:0] csa_q, csb_q, csc_q;
    logic [DIV_W-1:0] baud_divisor_q;
    logic wr_data, wr_divl, rd_data, enable;
    logic sync_mode_select, double_speed_bit, xfer_clock_pin_direction, sync_clock_polarity;
    logic [3:0] nbits;
    ucbg_pkg::ucbg_mode_e mode;

    assign wr_data = reg_wr && reg_addr == ucbg_pkg::ADDR_DATA;
    assign wr_divl = reg_wr && reg_addr == ucbg_pkg::ADDR_DIVL;
    assign rd_data = reg_rd && reg_addr == ucbg_pkg::ADDR_DATA;
    // unit held idle while the power-reduction bit is set
    assign enable = !power_reduce_serial_zero; // RQ18
    assign sync_mode_select = csc_q[ucbg_pkg::CSC_MSEL];
    assign double_speed_bit = csa_q[ucbg_pkg::CSA_U2X];
    assign xfer_clock_pin_direction = csc_q[ucbg_pkg::CSC_DIR];
    assign sync_clock_polarity = csc_q[ucbg_pkg::CSC_POL];
    assign nbits = {1'b0, csb_q[ucbg_pkg::CSB_SZ2], csc_q[ucbg_pkg::CSC_SZ1],
                    csc_q[ucbg_pkg::CSC_SZ0]} + ucbg_pkg::BITS_MIN;

    always_comb begin
        if (!sync_mode_select) begin // RQ2
            mode = double_speed_bit ? ucbg_pkg::UCBG_DBL : ucbg_pkg::UCBG_NORM; // RQ3
        end else begin
            mode = xfer_clock_pin_direction ? ucbg_pkg::UCBG_SMAST : ucbg_pkg::UCBG_SSLV; // RQ4 RQ1
        end
    end

    // ---------------------------------------------------------------
    // baud generator
    // ---------------------------------------------------------------
    logic [DIV_W-1:0] bcnt_q;
    logic baud_tick;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bcnt_q <= '0;
        end else if (wr_divl || bcnt_q == '0) begin
            bcnt_q <= wr_divl ? {baud_divisor_q[DIV_W-1:8], reg_wdata} : baud_divisor_q; // RQ7
        end else begin
            bcnt_q <= bcnt_q - 1'b1; // RQ7
        end
    end
    assign baud_tick = enable && bcnt_q == '0 && !wr_divl; // RQ8 RQ6

    function automatic logic [3:0] div_top(input ucbg_pkg::ucbg_mode_e m);
        case (m)
            ucbg_pkg::UCBG_NORM: div_top = ucbg_pkg::DIV_NORM;
            ucbg_pkg::UCBG_DBL: div_top = ucbg_pkg::DIV_DBL; // RQ21
            default: div_top = ucbg_pkg::DIV_SYNC;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // transfer clock: master output, slave synchroniser and edges
    // ---------------------------------------------------------------
    logic xs1_q, xs2_q, xs3_q, xclk_q, xrise, xfall;
    logic [3:0] tdiv_q;
    logic tx_step, rx_sync_sample;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
        end else begin
            xs1_q <= transfer_clock_pin_in; // RQ17 RQ20
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
        end
    end
    assign xrise = mode == ucbg_pkg::UCBG_SSLV && xs2_q && !xs3_q; // RQ20 RQ5
    assign xfall = mode == ucbg_pkg::UCBG_SSLV && !xs2_q && xs3_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tdiv_q <= '0;
        end else if (baud_tick) begin
            tdiv_q <= tdiv_q >= div_top(mode) ? 4'h0 : tdiv_q + 4'h1; // RQ9 RQ11
        end
    end
    // master clock toggles on each baud tick: period two ticks
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            xclk_q <= 1'b0;
        end else if (mode != ucbg_pkg::UCBG_SMAST) begin
            xclk_q <= 1'b0;
        end else if (baud_tick) begin
            xclk_q <= !xclk_q;
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            transfer_clock_pin_out <= 1'b0;
            transfer_clock_pin_oe <= 1'b0;
        end else begin
            transfer_clock_pin_out <= xclk_q ^ sync_clock_polarity;
            transfer_clock_pin_oe <= mode == ucbg_pkg::UCBG_SMAST && enable; // RQ5
        end
    end

    always_comb begin
        case (mode)
            ucbg_pkg::UCBG_SSLV: begin
                // data changes on the edge opposite the sampling edge
                tx_step = sync_clock_polarity ? xfall : xrise; // RQ23 RQ22
                rx_sync_sample = sync_clock_polarity ? xrise : xfall; // RQ22
            end
            ucbg_pkg::UCBG_SMAST: begin
                tx_step = baud_tick && !xclk_q; // RQ9
                rx_sync_sample = baud_tick && xclk_q; // RQ22 RQ16
            end
            default: begin
                tx_step = baud_tick && tdiv_q == div_top(mode); // RQ9 RQ11
                rx_sync_sample = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // transmitter: buffer plus shift register
    // ---------------------------------------------------------------
    ucbg_pkg::ucbg_fsm_e tst_q;
    logic [8:0] tbuf_q, tsh_q;
    logic tbuf_full_q, tpar_q;
    logic [3:0] tcnt_q;
    logic tx_go;
    assign tx_go = csb_q[ucbg_pkg::CSB_TXEN] && enable;

    function automatic logic par_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < n) p = p ^ d[i];
        end
        par_of = p;
    endfunction

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tst_q <= ucbg_pkg::UCBG_IDLE;
            tbuf_q <= '0;
            tbuf_full_q <= 1'b0;
            tsh_q <= '0;
            tcnt_q <= '0;
            tpar_q <= 1'b0;
            txd_out <= 1'b1;
        end else begin
            if (wr_data && !tbuf_full_q) begin
                tbuf_q <= {csb_q[ucbg_pkg::CSB_TXB8], reg_wdata}; // RQ13
                tbuf_full_q <= 1'b1;
            end
            if (!tx_go) begin
                tst_q <= ucbg_pkg::UCBG_IDLE;
                txd_out <= 1'b1;
            end else if (tx_step) begin
                case (tst_q)
                    ucbg_pkg::UCBG_IDLE: begin
                        if (tbuf_full_q) begin
                            tsh_q <= tbuf_q; // RQ13
                            tpar_q <= par_of(tbuf_q, nbits, csc_q[ucbg_pkg::CSC_PM0]);
                            tbuf_full_q <= 1'b0;
                            txd_out <= 1'b0;
                            tcnt_q <= '0;
                            tst_q <= ucbg_pkg::UCBG_DATA;
                        end
                    end
                    ucbg_pkg::UCBG_DATA: begin
                        txd_out <= tsh_q[0];
                        tsh_q <= {1'b0, tsh_q[8:1]};
                        tcnt_q <= tcnt_q + 4'h1;
                        if (tcnt_q + 4'h1 == nbits) begin
                            tst_q <= csc_q[ucbg_pkg::CSC_PM1] ? ucbg_pkg::UCBG_PAR
                                                              : ucbg_pkg::UCBG_STOP1;
                        end
                    end
                    ucbg_pkg::UCBG_PAR: begin
                        txd_out <= tpar_q;
                        tst_q <= ucbg_pkg::UCBG_STOP1;
                    end
                    ucbg_pkg::UCBG_STOP1: begin
                        txd_out <= 1'b1;
                        tst_q <= csc_q[ucbg_pkg::CSC_SBS] ? ucbg_pkg::UCBG_STOP2
                                                          : ucbg_pkg::UCBG_IDLE;
                    end
                    default: begin
                        txd_out <= 1'b1;
                        tst_q <= ucbg_pkg::UCBG_IDLE;
                    end
                endcase
            end
        end
    end
    // frame end: leaving a stop bit with nothing waiting
    logic tx_done;
    assign tx_done = tx_go && tx_step && !tbuf_full_q &&
        ((tst_q == ucbg_pkg::UCBG_STOP1 && !csc_q[ucbg_pkg::CSC_SBS]) ||
         tst_q == ucbg_pkg::UCBG_STOP2);

    // ---------------------------------------------------------------
    // receiver: recovery, shift register, two-entry buffer
    // ---------------------------------------------------------------
    ucbg_pkg::ucbg_fsm_e rst_q;
    logic [3:0] rph_q, rcnt_q;
    logic [8:0] rsh_q;
    logic rsmp, rx_go, rpar_err_q;
    logic [11:0] rfifo_q [2];
    logic [1:0] rlev_q;
    logic rx_push;
    logic [11:0] rx_word;
    assign rx_go = csb_q[ucbg_pkg::CSB_RXEN] && enable;

    // async: sample at phase mid-bit; sync: sample on transfer clock edge
    always_comb begin
        if (sync_mode_select) begin
            rsmp = rx_sync_sample; // RQ16
        end else begin
            rsmp = baud_tick && rph_q == (div_top(mode) >> 1); // RQ10 RQ21
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_q <= ucbg_pkg::UCBG_IDLE;
            rph_q <= '0;
            rcnt_q <= '0;
            rsh_q <= '0;
            rpar_err_q <= 1'b0;
        end else if (!rx_go) begin
            rst_q <= ucbg_pkg::UCBG_IDLE;
            rph_q <= '0;
        end else begin
            // recovery phase runs on the undivided baud tick
            if (baud_tick) begin
                rph_q <= (rst_q == ucbg_pkg::UCBG_IDLE && rxd_in) || rph_q >= div_top(mode)
                         ? 4'h0 : rph_q + 4'h1; // RQ10
            end
            if (rsmp) begin
                case (rst_q)
                    ucbg_pkg::UCBG_IDLE: begin
                        // false start bit is ignored
                        if (!rxd_in) begin
                            rcnt_q <= '0;
                            rsh_q <= '0;
                            rst_q <= ucbg_pkg::UCBG_DATA;
                        end
                    end
                    ucbg_pkg::UCBG_DATA: begin
                        rsh_q <= {1'b0, rsh_q[8:1]} | ({8'h00, rxd_in} << (nbits - 4'h1));
                        rcnt_q <= rcnt_q + 4'h1;
                        if (rcnt_q + 4'h1 == nbits) begin
                            rst_q <= csc_q[ucbg_pkg::CSC_PM1] ? ucbg_pkg::UCBG_PAR
                                                              : ucbg_pkg::UCBG_STOP1;
                        end
                        rpar_err_q <= 1'b0;
                    end
                    ucbg_pkg::UCBG_PAR: begin
                        rpar_err_q <= par_of(rsh_q, nbits, csc_q[ucbg_pkg::CSC_PM0]) != rxd_in;
                        rst_q <= ucbg_pkg::UCBG_STOP1;
                    end
                    default: rst_q <= ucbg_pkg::UCBG_IDLE;
                endcase
            end
        end
    end
    // second stop bit is not checked
    assign rx_push = rx_go && rsmp && rst_q == ucbg_pkg::UCBG_STOP1;
    // word: {overrun, parity, framing, data9}
    assign rx_word = {rlev_q == 2'h2 && !rd_data, rpar_err_q, !rxd_in, rsh_q}; // RQ15

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rfifo_q[0] <= '0;
            rfifo_q[1] <= '0;
            rlev_q <= '0;
        end else begin
            if (rd_data && rlev_q != 2'h0) begin
                rfifo_q[0] <= rfifo_q[1]; // RQ14
            end
            if (rx_push) begin
                if (rlev_q == 2'h0 || (rlev_q == 2'h1 && rd_data)) begin
                    rfifo_q[0] <= rx_word;
                end else if (rlev_q == 2'h1 || rd_data) begin
                    rfifo_q[1] <= rx_word; // RQ14
                end else begin
                    rfifo_q[1][11] <= 1'b1; // RQ15
                end
            end
            if (rx_push && !(rlev_q == 2'h2 && !rd_data) && !(rd_data && rlev_q != 2'h0)) begin
                rlev_q <= rlev_q + 2'h1;
            end else if (!rx_push && rd_data && rlev_q != 2'h0) begin
                rlev_q <= rlev_q - 2'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // register writes and reads
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            csa_q <= ucbg_pkg::CSA_RST;
            csb_q <= '0;
            csc_q <= ucbg_pkg::CSC_RST;
            baud_divisor_q <= '0;
        end else begin
            // set wins over a software clear in the same cycle
            csa_q[ucbg_pkg::CSA_TXC] <= tx_done ||
                (csa_q[ucbg_pkg::CSA_TXC] &&
                 !(reg_wr && reg_addr == ucbg_pkg::ADDR_CSA && reg_wdata[ucbg_pkg::CSA_TXC]));
            csa_q[ucbg_pkg::CSA_DRE] <= !(tbuf_full_q || (wr_data && !tbuf_full_q));
            csa_q[ucbg_pkg::CSA_RXC] <= rlev_q != 2'h0;
            csa_q[ucbg_pkg::CSA_FE] <= rfifo_q[0][9];
            csa_q[ucbg_pkg::CSA_PE] <= rfifo_q[0][10];
            csa_q[ucbg_pkg::CSA_DOR] <= rfifo_q[0][11];
            csb_q[ucbg_pkg::CSB_RXB8] <= rfifo_q[0][8];
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_CSA) begin
                csa_q[ucbg_pkg::CSA_U2X] <= reg_wdata[ucbg_pkg::CSA_U2X];
            end
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_CSB) begin
                csb_q[7:2] <= reg_wdata[7:2];
                csb_q[ucbg_pkg::CSB_TXB8] <= reg_wdata[ucbg_pkg::CSB_TXB8];
            end
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_CSC) begin
                csc_q <= reg_wdata;
            end
            if (wr_divl) begin
                baud_divisor_q[7:0] <= reg_wdata; // RQ12
            end
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_DIVH) begin
                baud_divisor_q[DIV_W-1:8] <= reg_wdata[DIV_W-9:0]; // RQ12
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                ucbg_pkg::ADDR_DATA: reg_rdata <= rfifo_q[0][7:0];
                ucbg_pkg::ADDR_CSA: reg_rdata <= csa_q;
                ucbg_pkg::ADDR_CSB: reg_rdata <= csb_q;
                ucbg_pkg::ADDR_CSC: reg_rdata <= csc_q;
                ucbg_pkg::ADDR_DIVL: reg_rdata <= baud_divisor_q[7:0];
                ucbg_pkg::ADDR_DIVH: reg_rdata <= {{(16 - DIV_W){1'b0}}, baud_divisor_q[DIV_W-1:8]};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ---------------------------------------------------------------
    // interrupt request levels
    // ---------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_rx_complete <= 1'b0;
            irq_tx_complete <= 1'b0;
            irq_data_empty <= 1'b0;
        end else begin
            irq_rx_complete <= csa_q[ucbg_pkg::CSA_RXC] && csb_q[7]; // RQ19
            irq_tx_complete <= csa_q[ucbg_pkg::CSA_TXC] && csb_q[6]; // RQ19
            irq_data_empty <= csa_q[ucbg_pkg::CSA_DRE] && csb_q[5]; // RQ19
        end
    end
endmodule
`default_nettype wire

/* tb/ucbg_assertions.sv */
// ucbg_assertions: port-level checks of the serial clock generator.
// assumes: sees only ucbg_top ports; mode bits shadowed from register writes.
`timescale 1ns/1ps
`default_nettype none
module ucbg_checker #(
    parameter int DIV_W = 12
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic power_reduce_serial_zero,
    input wire logic txd_out,
    input wire logic transfer_clock_pin_out,
    input wire logic transfer_clock_pin_oe,
    input wire logic irq_rx_complete,
    input wire logic irq_tx_complete,
    input wire logic irq_data_empty
);
    // ---------------------------------------------------------------
    // shadows of mode, enables and divisor
    // ---------------------------------------------------------------
    logic [1:0] csc_q;
    logic [2:0] en_q;
    logic [11:0] div_q;
    logic [15:0] cnt_q;
    logic seen_q;
    logic pin_q;
    wire tgl = transfer_clock_pin_out != pin_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            csc_q <= 2'h0;
            en_q <= 3'h0;
            div_q <= 12'h000;
            cnt_q <= 16'h0000;
            seen_q <= 1'b1;
            pin_q <= 1'b0;
        end else begin
            pin_q <= transfer_clock_pin_out;
            cnt_q <= tgl ? 16'h0000 : cnt_q + 16'h0001;
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_CSC) csc_q <= reg_wdata[7:6];
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_CSB) en_q <= reg_wdata[7:5];
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_DIVL) div_q[7:0] <= reg_wdata;
            if (reg_wr && reg_addr == ucbg_pkg::ADDR_DIVH) div_q[11:8] <= reg_wdata[3:0];
            // a fresh setting spoils the first interval after it
            if ((reg_wr && reg_addr >= ucbg_pkg::ADDR_CSC) || power_reduce_serial_zero) begin
                seen_q <= 1'b1;
            end else if (tgl) begin
                seen_q <= 1'b0;
            end
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    a_oe_master_only: assert property (@(posedge mclk) disable iff (sys_rst)
        transfer_clock_pin_oe |-> $past(csc_q) == 2'h3) else $error("pin driven outside master");
    a_oe_power_off: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(power_reduce_serial_zero) |-> !transfer_clock_pin_oe) else $error("pin driven when off");
    a_pin_half_period: assert property (@(posedge mclk) disable iff (sys_rst)
        tgl && transfer_clock_pin_oe && $past(transfer_clock_pin_oe) && !seen_q
        |-> cnt_q == {4'h0, div_q}) else $error("master clock phase length wrong");
    a_rdata_idle_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
    a_unmapped_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(reg_rd) && $past(reg_addr) > 3'h5 |-> reg_rdata == 8'h00) else $error("unmapped read");
    a_txd_idle_off: assert property (@(posedge mclk) disable iff (sys_rst)
        power_reduce_serial_zero [*2] |=> txd_out) else $error("txd not idle when off");
    a_irq_rx_en: assert property (@(posedge mclk) disable iff (sys_rst)
        irq_rx_complete |-> en_q[2] || $past(en_q[2])) else $error("rx irq while masked");
    a_irq_tx_en: assert property (@(posedge mclk) disable iff (sys_rst)
        irq_tx_complete |-> en_q[1] || $past(en_q[1])) else $error("tx irq while masked");
    a_irq_dre_en: assert property (@(posedge mclk) disable iff (sys_rst)
        irq_data_empty |-> en_q[0] || $past(en_q[0])) else $error("empty irq while masked");
endmodule
bind ucbg_top ucbg_checker #(.DIV_W(DIV_W)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_reduce_serial_zero(power_reduce_serial_zero),
    .txd_out(txd_out), .transfer_clock_pin_out(transfer_clock_pin_out),
    .transfer_clock_pin_oe(transfer_clock_pin_oe), .irq_rx_complete(irq_rx_complete),
    .irq_tx_complete(irq_tx_complete), .irq_data_empty(irq_data_empty));
`default_nettype wire

/* tb/ucbg_peer.sv */
// ucbg_peer: remote line partner; echoes the line and times the start bit.
// assumes: runs on mclk; line idles high.
`timescale 1ns/1ps
`default_nettype none
module ucbg_peer (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic txd,
    output logic rxd,
    output logic xck,
    output logic [15:0] low_len
);
    logic [15:0] cnt_q;
    logic [3:0] ph_q;
    logic txd_q;
    // slave clock runs free, 16 mclk per period
    assign xck = ph_q[3];
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rxd <= 1'b1;
            txd_q <= 1'b1;
            cnt_q <= 16'h0000;
            ph_q <= 4'h0;
            low_len <= 16'h0000;
        end else begin
            ph_q <= ph_q + 4'h1;
            rxd <= txd;
            txd_q <= txd;
            cnt_q <= txd ? 16'h0000 : cnt_q + 16'h0001;
            if (txd && !txd_q) low_len <= cnt_q;
        end
    end
endmodule
`default_nettype wire

/* tb/usart_clock_baud_generation_tb_top.sv */
// usart_clock_baud_generation_tb_top: table of clock modes plus hand tests.
// assumes: peer echoes txd to rxd; pin input sees our own clock when driven.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module usart_clock_baud_generation_tb_top;
    logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pr = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
    logic rxd, txd, pin_o, pin_oe, irq_rx, irq_tx, irq_de, sclk;
    logic [15:0] low_len;
    int n_fail = 0, num_checks = 0;
    // csa, csc, divh, divl, start bit length, pin driven
    logic [55:0] rows [5] = '{{8'h20, 8'h06, 8'h00, 8'h02, 16'd48, 8'h00},
        {8'h22, 8'h06, 8'h00, 8'h02, 16'd24, 8'h00}, {8'h20, 8'h46, 8'h00, 8'h02, 16'd16, 8'h00},
        {8'h22, 8'hc6, 8'h00, 8'h02, 16'd6, 8'h01}, {8'h20, 8'hc6, 8'h01, 8'h00, 16'd514, 8'h01}};
    ucbg_top dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_reduce_serial_zero(pr), .rxd_in(rxd), .txd_out(txd),
        .transfer_clock_pin_in(pin_oe ? pin_o : sclk), .transfer_clock_pin_out(pin_o),
        .transfer_clock_pin_oe(pin_oe), .irq_rx_complete(irq_rx), .irq_tx_complete(irq_tx),
        .irq_data_empty(irq_de));
    ucbg_peer peer (.mclk(mclk), .sys_rst(sys_rst), .txd(txd), .rxd(rxd), .low_len(low_len),
        .xck(sclk));
    initial forever #25 mclk = ~mclk;
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic summarize();
        $display("checks=%0d failures=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // watchdog: whole run must finish within 30k cycles
    // ---------------------------------------------------------------
    initial begin
        #(30000 * 50);
        n_fail++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(ucbg_pkg::ADDR_CSA, d); `CHK(d, ucbg_pkg::CSA_RST)
        rd(ucbg_pkg::ADDR_CSC, d); `CHK(d, ucbg_pkg::CSC_RST)
        wr(3'h6, 8'hff);
        rd(3'h6, d); `CHK(d, 8'h00)
        pr <= 1'b0;
        wr(ucbg_pkg::ADDR_CSB, 8'hf8);
        foreach (rows[i]) begin
            wr(ucbg_pkg::ADDR_CSA, rows[i][55:48]);
            wr(ucbg_pkg::ADDR_CSC, rows[i][47:40]);
            wr(ucbg_pkg::ADDR_DIVH, rows[i][39:32]);
            wr(ucbg_pkg::ADDR_DIVL, rows[i][31:24]);
            repeat (2) @(posedge mclk);
            `CHK(pin_oe, rows[i][0])
            wr(ucbg_pkg::ADDR_DATA, 8'h55);
            repeat (12 * rows[i][23:8]) @(posedge mclk);
            `CHK(low_len, rows[i][23:8])
            `CHK({irq_rx, irq_tx, irq_de}, 3'h7)
            rd(ucbg_pkg::ADDR_DATA, d); `CHK(d, 8'h55)
        end
        pr <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(pin_oe, 1'b0)
        summarize();
    end
endmodule
`default_nettype wire
